// ---- design/dbra_top.sv ----
/*
  register space access logic reachable from a PCI target port and VMEbus pins,
  with arbitration between the two buses and CR/CSR forwarding to PCI.
  assumes PCI requests and the forward port come from logic on CLK, and that
  VMEbus pins and straps are asynchronous levels.
*/
`include "dbra_map.svh"
`default_nettype none
module dbra_top
  import dbra_pkg::*;
#(
  parameter int WORDS = 1024
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PCI_REQ,
  input wire dbra_pci_kind_e PCI_KIND,
  input wire logic PCI_IDSEL,
  input wire logic [31:0] PCI_ADDR,
  input wire logic PCI_WRITE,
  input wire logic [3:0] PCI_BE_N,
  input wire logic [31:0] PCI_WDATA,
  input wire logic PCI_BURST,
  input wire logic PCI_LOCK,
  output logic PCI_DONE,
  output logic PCI_RETRY,
  output logic PCI_NOSEL,
  output logic PCI_DISC,
  output logic [31:0] PCI_RDATA,
  input wire logic VME_AS_N,
  input wire logic VME_DS_N,
  input wire logic VME_WRITE_N,
  input wire logic VME_BBSY_N,
  input wire logic [5:0] VME_AM,
  input wire logic [31:0] VME_ADDR,
  input wire logic [31:0] VME_DATA_I,
  output logic [31:0] VME_DATA_O,
  output logic VME_DATA_OE_N,
  output logic VME_DTACK_N,
  input wire logic STRAP_ADDR_LINE,
  input wire logic STRAP_IMAGE_EN,
  input wire logic [19:0] STRAP_IMAGE_BASE,
  output logic FWD_REQ,
  output logic [31:0] FWD_ADDR,
  output logic [1:0] FWD_CMD,
  output logic FWD_WRITE,
  output logic [31:0] FWD_WDATA,
  input wire logic FWD_DONE,
  input wire logic [31:0] FWD_RDATA
);
  localparam int SW = 96;

  dbra_state_s r_q;
  dbra_state_s r_d;
  logic [31:0] mem [WORDS];
  logic [SW-1:0] sync_in;
  logic [SW-1:0] sync_out;
  logic as_s, ds_s, wr_n_s, bbsy_s, strap_s, strap_en_s;
  logic [5:0] am_s;
  logic [31:0] addr_s, data_s;
  logic [19:0] strap_base_s;
  logic wr_en, mem_we;
  logic [9:0] wr_idx;
  logic [31:0] wr_data;
  logic [3:0] wr_be;
  logic pci_hit, pci_take;
  logic [9:0] pci_idx;
  logic img_hit, cs_hit, cs_reg;

  // every VMEbus pin and strap passes two flip-flops
  assign sync_in = {VME_AS_N, VME_DS_N, VME_WRITE_N, VME_BBSY_N, VME_AM, VME_ADDR,
                    VME_DATA_I, STRAP_ADDR_LINE, STRAP_IMAGE_EN, STRAP_IMAGE_BASE};
  dbra_sync #(.W(SW)) u_sync (
    .clk(CLK),
    .rst(RESET),
    .d(sync_in),
    .q(sync_out)
  );
  assign {as_s, ds_s, wr_n_s, bbsy_s, am_s, addr_s, data_s, strap_s, strap_en_s,
          strap_base_s} = sync_out;

  // byte lane merge, lane i is byte address i
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return m;
  endfunction

  // register read, held registers first, array otherwise
  function automatic logic [31:0] rd_reg(input logic [9:0] idx);
    logic [11:0] off;
    off = {idx, 2'b00};
    case (off)
      `DBRA_OFF_WIN0: return r_q.win0;
      `DBRA_OFF_WIN1: return r_q.win1;
      `DBRA_OFF_IMG_CTL: return r_q.img_ctl;
      `DBRA_OFF_IMG_BASE: return r_q.img_base;
      `DBRA_OFF_CS_CTL: return r_q.cs_ctl;
      `DBRA_OFF_CS_TO: return r_q.cs_to;
      `DBRA_OFF_CS_BASE: return r_q.cs_base;
      default: return mem[idx];
    endcase
  endfunction

  // memory or I/O window match on base upper bits and space bit
  function automatic logic win_hit(input logic [31:0] base, input logic [31:0] a,
                                   input logic io);
    return (base[0] == io) && (a[31:12] == base[31:12]);
  endfunction

  // address space from the address modifier
  function automatic dbra_space_e am_space(input logic [5:0] am);
    case (am)
      6'h09, 6'h0A, 6'h0D, 6'h0E: return SP_A32;
      6'h39, 6'h3A, 6'h3D, 6'h3E: return SP_A24;
      6'h29, 6'h2D: return SP_A16;
      6'h2F: return SP_CRCSR;
      default: return SP_NONE;
    endcase
  endfunction

  // PCI decode
  always_comb begin
    pci_idx = PCI_ADDR[11:2];
    pci_hit = 1'b0;
    case (PCI_KIND)
      KIND_CFG: begin
        pci_hit = PCI_IDSEL;
        pci_idx = {4'h0, PCI_ADDR[7:2]};
      end
      KIND_MEM: pci_hit = win_hit(r_q.win0, PCI_ADDR, 1'b0) || win_hit(r_q.win1, PCI_ADDR, 1'b0);
      KIND_IO: pci_hit = win_hit(r_q.win0, PCI_ADDR, 1'b1) || win_hit(r_q.win1, PCI_ADDR, 1'b1);
      default: pci_hit = 1'b0;
    endcase
    pci_take = PCI_REQ && pci_hit && (r_q.strap_cnt == `DBRA_READY_CYC) &&
               !(r_q.pci_done || r_q.pci_retry || r_q.pci_nosel);
  end

  // VMEbus decode
  always_comb begin
    dbra_space_e sp;
    logic qual;
    sp = am_space(am_s);
    qual = (am_s[2] ? r_q.img_ctl[`DBRA_F_SUP_SUPER] : r_q.img_ctl[`DBRA_F_SUP_USER]) &&
           ((am_s[1:0] == 2'b10) ? r_q.img_ctl[`DBRA_F_PGM_PROG] :
            r_q.img_ctl[`DBRA_F_PGM_DATA]);
    img_hit = 1'b0;
    // image compare width follows the space
    if (r_q.img_ctl[`DBRA_F_EN] && qual && (sp != SP_NONE) && (sp != SP_CRCSR) &&
        (sp == dbra_space_e'({1'b0, r_q.img_ctl[`DBRA_F_VAS_HI:`DBRA_F_VAS_LO]}))) begin
      case (sp)
        SP_A16: img_hit = addr_s[15:12] == r_q.img_base[15:12];
        SP_A24: img_hit = addr_s[23:12] == r_q.img_base[23:12];
        default: img_hit = addr_s[31:12] == r_q.img_base[31:12];
      endcase
    end
    // slot match on 512 Kbyte blocks
    cs_hit = r_q.cs_ctl[`DBRA_F_EN] && (sp == SP_CRCSR) &&
             (addr_s[23:19] == r_q.cs_base[`DBRA_F_SLOT_HI:`DBRA_F_SLOT_LO]);
    // top 4 Kbytes of the slot
    cs_reg = addr_s[18:12] == `DBRA_CS_REG_BLK;
  end

  // next state
  always_comb begin
    r_d = r_q;
    wr_en = 1'b0;
    wr_idx = '0;
    wr_data = '0;
    wr_be = '0;
    mem_we = 1'b0;
    r_d.pci_done = 1'b0;
    r_d.pci_retry = 1'b0;
    r_d.pci_nosel = 1'b0;
    r_d.pci_disc = 1'b0;
    // straps caught after release, windows complementary
    if (r_q.strap_cnt != `DBRA_READY_CYC) begin
      r_d.strap_cnt = r_q.strap_cnt + 2'h1;
      if (r_q.strap_cnt == `DBRA_STRAP_CYC) begin
        r_d.win0[0] = ~strap_s;
        r_d.win1[0] = strap_s;
        if (strap_en_s) begin
          r_d.img_base = {strap_base_s, 12'h000};
        end
      end
    end
    if (!PCI_LOCK) begin
      r_d.pci_lock = 1'b0;
    end
    // PCI request answer
    if (PCI_REQ && !(r_q.pci_done || r_q.pci_retry || r_q.pci_nosel) &&
        (r_q.strap_cnt == `DBRA_READY_CYC)) begin
      if (!pci_hit) begin
        r_d.pci_nosel = 1'b1;
      // retry while VMEbus holds the space
      end else if ((r_q.vme_hold || r_q.adoh_lock) && !r_q.pci_lock) begin
        r_d.pci_retry = 1'b1;
      end else begin
        r_d.pci_done = 1'b1;
        r_d.pci_disc = PCI_BURST;
        r_d.pci_lock = PCI_LOCK;
        if (PCI_WRITE) begin
          wr_en = 1'b1;
          wr_idx = pci_idx;
          wr_data = PCI_WDATA;
          wr_be = ~PCI_BE_N;
        end else begin
          r_d.pci_rdata = rd_reg(pci_idx);
        end
      end
    end
    // lock ends with bus busy negated
    if (bbsy_s) begin
      r_d.adoh_lock = 1'b0;
    end
    case (r_q.vst)
      V_IDLE: begin
        if (!as_s && (img_hit || cs_hit)) begin
          r_d.vme_hold = 1'b1;
          r_d.ds_seen = 1'b0;
          r_d.v_idx = addr_s[11:2];
          // non register CR/CSR cycles go to PCI with offset
          r_d.v_fwd = cs_hit && !cs_reg;
          r_d.fwd_addr = {8'h00, addr_s[23:0]} + r_q.cs_to;
          r_d.fwd_cmd = r_q.cs_ctl[1:0];
          r_d.vst = V_WAIT;
        end
      end
      V_WAIT: begin
        // any data strobe, acknowledged or not, means this is no address-only cycle
        r_d.ds_seen = r_q.ds_seen || !ds_s;
        if (as_s) begin
          r_d.vme_hold = 1'b0;
          // address only cycle locks the space
          if (!r_q.ds_seen) begin
            r_d.adoh_lock = 1'b1;
          end
          r_d.vst = V_IDLE;
        // no acknowledge while PCI holds the lock
        end else if (!ds_s && !r_q.pci_lock) begin
          r_d.ds_seen = 1'b1;
          if (r_q.v_fwd) begin
            r_d.fwd_req = 1'b1;
            r_d.fwd_write = !wr_n_s;
            r_d.fwd_wdata = data_s;
            r_d.vst = V_FWD;
          end else begin
            if (!wr_n_s) begin
              wr_en = 1'b1;
              wr_idx = r_q.v_idx;
              wr_data = data_s;
              wr_be = 4'hF;
            end else begin
              r_d.vme_dout = rd_reg(r_q.v_idx);
              r_d.vme_oe_n = 1'b0;
            end
            r_d.dtack_n = 1'b0;
            r_d.vst = V_ACK;
          end
        end
      end
      // back to wait with AS held keeps tenure for the write
      V_ACK: begin
        if (ds_s) begin
          r_d.dtack_n = 1'b1;
          r_d.vme_oe_n = 1'b1;
          r_d.vst = V_WAIT;
        end
      end
      V_FWD: begin
        if (FWD_DONE) begin
          r_d.fwd_req = 1'b0;
          r_d.vme_dout = FWD_RDATA;
          r_d.vme_oe_n = r_q.fwd_write;
          r_d.dtack_n = 1'b0;
          r_d.vst = V_ACK;
        end
      end
      default: r_d.vst = V_IDLE;
    endcase
    // window bases from either bus, space bit kept
    if (wr_en) begin
      case ({wr_idx, 2'b00})
        `DBRA_OFF_WIN0: r_d.win0 = merge(r_q.win0, wr_data & 32'hFFFF_F000, wr_be & 4'hE);
        `DBRA_OFF_WIN1: r_d.win1 = merge(r_q.win1, wr_data & 32'hFFFF_F000, wr_be & 4'hE);
        `DBRA_OFF_IMG_CTL: r_d.img_ctl = merge(r_q.img_ctl, wr_data, wr_be);
        `DBRA_OFF_IMG_BASE: r_d.img_base = merge(r_q.img_base, wr_data & 32'hFFFF_F000, wr_be);
        `DBRA_OFF_CS_CTL: r_d.cs_ctl = merge(r_q.cs_ctl, wr_data, wr_be);
        `DBRA_OFF_CS_TO: r_d.cs_to = merge(r_q.cs_to, wr_data, wr_be);
        `DBRA_OFF_CS_BASE: r_d.cs_base = merge(r_q.cs_base, wr_data, wr_be);
        default: mem_we = 1'b1;
      endcase
    end
  end

  // state register
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      r_q <= '0;
      r_q.vst <= V_IDLE;
      r_q.img_ctl <= `DBRA_RST_IMG_CTL;
      r_q.vme_oe_n <= 1'b1;
      r_q.dtack_n <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (mem_we) begin
      mem[wr_idx] <= merge(mem[wr_idx], wr_data, wr_be);
    end
  end

  assign PCI_DONE = r_q.pci_done;
  assign PCI_RETRY = r_q.pci_retry;
  assign PCI_NOSEL = r_q.pci_nosel;
  assign PCI_DISC = r_q.pci_disc;
  assign PCI_RDATA = r_q.pci_rdata;
  assign VME_DATA_O = r_q.vme_dout;
  assign VME_DATA_OE_N = r_q.vme_oe_n;
  assign VME_DTACK_N = r_q.dtack_n;
  assign FWD_REQ = r_q.fwd_req;
  assign FWD_ADDR = r_q.fwd_addr;
  assign FWD_CMD = r_q.fwd_cmd;
  assign FWD_WRITE = r_q.fwd_write;
  assign FWD_WDATA = r_q.fwd_wdata;

  a_retry_vme: assert property (@(posedge CLK) disable iff (RESET)
    (pci_take && r_q.vme_hold && !r_q.pci_lock) |=> PCI_RETRY && !PCI_DONE)
    else $error("PCI not retried while VMEbus holds space");
  a_adoh_hold: assert property (@(posedge CLK) disable iff (RESET)
    (r_q.adoh_lock && !bbsy_s) |=> r_q.adoh_lock)
    else $error("address only lock dropped early");
  a_lock_dtack: assert property (@(posedge CLK) disable iff (RESET)
    (r_q.pci_lock && r_q.dtack_n && r_q.vst == V_WAIT) |=> VME_DTACK_N)
    else $error("DTACK given during PCI lock");
  a_space_ro: assert property (@(posedge CLK) disable iff (RESET)
    (r_q.strap_cnt == `DBRA_READY_CYC) |=> $stable(r_q.win0[0]) && $stable(r_q.win1[0]))
    else $error("window space bit changed");
  a_space_pair: assert property (@(posedge CLK) disable iff (RESET)
    (r_q.strap_cnt == `DBRA_READY_CYC) |-> (r_q.win0[0] != r_q.win1[0]))
    else $error("window space bits not complementary");
  a_cfg_limit: assert property (@(posedge CLK) disable iff (RESET)
    (pci_take && PCI_KIND == KIND_CFG) |-> ({pci_idx, 2'b00} < `DBRA_CFG_LIMIT))
    else $error("config cycle beyond lowest 256 bytes");
  a_burst_disc: assert property (@(posedge CLK) disable iff (RESET)
    (pci_take && PCI_BURST && !r_q.vme_hold && !r_q.adoh_lock) |=> PCI_DONE && PCI_DISC)
    else $error("burst not disconnected");
  a_byte_lane: assert property (@(posedge CLK) disable iff (RESET)
    (mem_we && wr_be == 4'h1) |=> (mem[$past(wr_idx)][7:0] == $past(wr_data[7:0])))
    else $error("byte lane zero not stored at byte zero");
  a_cs_offset: assert property (@(posedge CLK) disable iff (RESET)
    (r_q.vst == V_IDLE && !as_s && cs_hit && cs_reg) |=> (r_q.v_idx == $past(addr_s[11:2])) && !r_q.v_fwd)
    else $error("CR/CSR register offset wrong");
endmodule
`default_nettype wire

// ---- design/dbra_map.svh ----
/*
  constants of the dual bus register access block: register offsets inside the
  4 Kbyte register space, field positions, reset values and strap timing.
  assumes it is included by bare name after the package file.
*/
`ifndef DBRA_MAP_SVH
`define DBRA_MAP_SVH

// register byte offsets
`define DBRA_OFF_WIN0 12'h010
`define DBRA_OFF_WIN1 12'h014
`define DBRA_OFF_IMG_CTL 12'hF70
`define DBRA_OFF_IMG_BASE 12'hF74
`define DBRA_OFF_CS_CTL 12'hF78
`define DBRA_OFF_CS_TO 12'hF7C
`define DBRA_OFF_CS_BASE 12'hFFC
// config cycles reach offsets below this
`define DBRA_CFG_LIMIT 12'h100
// upper slot bits that mark the register block in CR/CSR space
`define DBRA_CS_REG_BLK 7'h7F
// field positions
`define DBRA_F_EN 31
`define DBRA_F_PGM_PROG 23
`define DBRA_F_PGM_DATA 22
`define DBRA_F_SUP_SUPER 21
`define DBRA_F_SUP_USER 20
`define DBRA_F_VAS_HI 17
`define DBRA_F_VAS_LO 16
`define DBRA_F_SLOT_HI 23
`define DBRA_F_SLOT_LO 19
// reset values
`define DBRA_RST_WORD 32'h0000_0000
`define DBRA_RST_IMG_CTL 32'h00F0_0000
// strap sampling: cycles after reset release at which straps are caught
`define DBRA_STRAP_CYC 2'h2
`define DBRA_READY_CYC 2'h3

`endif

// ---- design/dbra_pkg.sv ----
/*
  types of the dual bus register access block.
  assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package dbra_pkg;
  // kind of PCI request
  typedef enum logic [1:0] {
    KIND_CFG = 2'h0,
    KIND_MEM = 2'h1,
    KIND_IO = 2'h2
  } dbra_pci_kind_e;
  // VMEbus access state, gray along idle, wait, ack
  typedef enum logic [1:0] {
    V_IDLE = 2'h0,
    V_WAIT = 2'h1,
    V_ACK = 2'h3,
    V_FWD = 2'h2
  } dbra_vstate_e;
  // address space decoded from the address modifier
  typedef enum logic [2:0] {
    SP_A16 = 3'h0,
    SP_A24 = 3'h1,
    SP_A32 = 3'h2,
    SP_CRCSR = 3'h3,
    SP_NONE = 3'h7
  } dbra_space_e;
  // state of the top module apart from the array
  typedef struct packed {
    dbra_vstate_e vst;
    logic [1:0] strap_cnt;
    logic [31:0] win0;
    logic [31:0] win1;
    logic [31:0] img_base;
    logic [31:0] img_ctl;
    logic [31:0] cs_ctl;
    logic [31:0] cs_base;
    logic [31:0] cs_to;
    logic vme_hold;
    logic adoh_lock;
    logic ds_seen;
    logic pci_lock;
    logic [9:0] v_idx;
    logic v_fwd;
    logic pci_done;
    logic pci_retry;
    logic pci_nosel;
    logic pci_disc;
    logic [31:0] pci_rdata;
    logic [31:0] vme_dout;
    logic vme_oe_n;
    logic dtack_n;
    logic fwd_req;
    logic [31:0] fwd_addr;
    logic [1:0] fwd_cmd;
    logic fwd_write;
    logic [31:0] fwd_wdata;
  } dbra_state_s;
endpackage
`default_nettype wire

// ---- design/dbra_sync.sv ----
/*
  two flip-flop synchroniser for a vector of pin levels.
  assumes each bit is a level that stays stable for several clocks.
*/
`default_nettype none
module dbra_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dbra_sync_s;

  dbra_sync_s r_q;
  dbra_sync_s r_d;

  // first stage feeds only the second
  always_comb begin
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign q = r_q.s2;
endmodule
`default_nettype wire

// ---- testbench/dbra_fwd_model.sv ----
/*
  partner model of the PCI master logic behind the forward port: answers each
  forward request after a set delay with a fixed read word.
  assumes the forward port of the register block runs on the same clock.
*/
`default_nettype none
module dbra_fwd_model (
  input wire logic clk,
  input wire logic [3:0] delay,
  input wire logic fwd_req,
  input wire logic [31:0] rd_val,
  output logic fwd_done,
  output logic [31:0] fwd_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt = 4'h0;
  initial fwd_done = 1'b0;
  initial fwd_rdata = 32'h0;
  // count out the delay, then one answer pulse; data is scrambled outside it
  always @(posedge clk) begin
    fwd_done <= 1'b0;
    fwd_rdata <= ~fwd_rdata;
    if (fwd_req && !fwd_done) begin
      cnt <= cnt + 4'h1;
      if (cnt >= delay) begin
        fwd_done <= 1'b1;
        fwd_rdata <= rd_val;
        cnt <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/dual_bus_register_access_test.sv ----
/*
  self-checking bench of the register block: drives the PCI port and VMEbus
  pins, notes each expected answer in a queue and checks answers as they show.
  assumes the design package, the map header and the forward port model.
*/
`include "dbra_map.svh"
`default_nettype none
module dual_bus_register_access_test
  import dbra_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [2:0] code; logic disc; logic rd; logic [31:0] data;} dbra_exp_s;
  localparam logic [2:0] DN = 3'h1, RT = 3'h2, NS = 3'h4;
  localparam logic [31:0] MB = 32'h4000_0000, IB = 32'h0000_6000, VB = 32'h0000_C000;
  localparam logic [31:0] TO = 32'h1000_0000, FV = 32'h5A5A_A5A5;
  localparam logic [31:0] CS = 32'h0018_0000 + 32'h0007_F000;
  localparam logic [31:0] OW0 = {20'h0, `DBRA_OFF_WIN0}, OW1 = {20'h0, `DBRA_OFF_WIN1};
  localparam logic [31:0] OIC = {20'h0, `DBRA_OFF_IMG_CTL}, OIB = {20'h0, `DBRA_OFF_IMG_BASE};
  localparam logic [31:0] OCC = {20'h0, `DBRA_OFF_CS_CTL}, OCT = {20'h0, `DBRA_OFF_CS_TO};
  localparam logic [31:0] OCB = {20'h0, `DBRA_OFF_CS_BASE};
  logic clk = 1'b0, rst = 1'b1, preq = 1'b0, pidsel = 1'b0, pwr = 1'b0, pburst = 1'b0;
  logic plock = 1'b0, as_n = 1'b1, ds_n = 1'b1, wr_n = 1'b1, bbsy_n = 1'b1;
  logic pdone, pretry, pnosel, pdisc, voe_n, dtack_n, freq, fwr, fdone, dt_q = 1'b1, fr_q = 1'b0;
  dbra_pci_kind_e pkind = KIND_CFG;
  logic [3:0] pbe_n = 4'h0, fdly = 4'h0;
  logic [5:0] am = 6'h0;
  logic [1:0] fcmd;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, vaddr = 32'h0, vdin = 32'h0, r;
  logic [31:0] prdata, vdout, faddr, fwdata, frdata;
  logic [5:0] amt [0:2] = '{6'h2D, 6'h3D, 6'h0D};
  dbra_exp_s pq[$];
  logic [32:0] vq[$];
  logic [66:0] fq[$];
  int n_fail = 0, checks_done = 0, seed = 80573;

  dbra_top dut (.CLK(clk), .RESET(rst), .PCI_REQ(preq), .PCI_KIND(pkind), .PCI_IDSEL(pidsel),
    .PCI_ADDR(paddr), .PCI_WRITE(pwr), .PCI_BE_N(pbe_n), .PCI_WDATA(pwdata),
    .PCI_BURST(pburst), .PCI_LOCK(plock), .PCI_DONE(pdone), .PCI_RETRY(pretry),
    .PCI_NOSEL(pnosel), .PCI_DISC(pdisc), .PCI_RDATA(prdata), .VME_AS_N(as_n),
    .VME_DS_N(ds_n), .VME_WRITE_N(wr_n), .VME_BBSY_N(bbsy_n), .VME_AM(am),
    .VME_ADDR(vaddr), .VME_DATA_I(vdin), .VME_DATA_O(vdout), .VME_DATA_OE_N(voe_n),
    .VME_DTACK_N(dtack_n), .STRAP_ADDR_LINE(1'b0), .STRAP_IMAGE_EN(1'b1),
    .STRAP_IMAGE_BASE(20'hABCDE), .FWD_REQ(freq), .FWD_ADDR(faddr), .FWD_CMD(fcmd),
    .FWD_WRITE(fwr), .FWD_WDATA(fwdata), .FWD_DONE(fdone), .FWD_RDATA(frdata));
  dbra_fwd_model partner (.clk(clk), .delay(fdly), .fwd_req(freq), .rd_val(FV),
    .fwd_done(fdone), .fwd_rdata(frdata));

  // free running clock
  initial forever #25 clk = ~clk;

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_out();
    chk("wait bound", 32'h0, 32'h1);
    test_done();
  endtask

  task automatic cmp_pci(input dbra_exp_s e);
    chk("pci answer", {29'h0, e.code}, {29'h0, pnosel, pretry, pdone});
    chk("pci disconnect", {31'h0, e.disc}, {31'h0, pdisc});
    if (e.rd) chk("pci read data", e.data, prdata);
  endtask

  task automatic cmp_vme(input logic [32:0] e);
    chk("vme drive", {31'h0, e[32]}, {31'h0, voe_n});
    if (!e[32]) chk("vme read data", e[31:0], vdout);
  endtask

  task automatic cmp_fwd(input logic [66:0] e);
    chk("fwd command", {30'h0, e[33:32]}, {30'h0, fcmd});
    chk("fwd address", e[31:0], faddr);
    chk("fwd write", {31'h0, e[66]}, {31'h0, fwr});
    if (e[66]) chk("fwd write data", e[65:34], fwdata);
  endtask

  function automatic logic ans();
    return pdone === 1'b1 || pretry === 1'b1 || pnosel === 1'b1;
  endfunction

  // one PCI request held until its answer pulse, then dropped
  task automatic pci(input dbra_pci_kind_e k, input logic [31:0] a, input logic w,
      input logic [31:0] d, input logic [3:0] be, input logic [2:0] fl,
      input logic [2:0] code, input logic [31:0] ed);
    int i;
    pq.push_back('{code, fl[0] & w, ~w & (code == DN), ed});
    @(posedge clk);
    pkind <= k;
    paddr <= a;
    pwr <= w;
    pwdata <= d;
    pbe_n <= be;
    pburst <= fl[0];
    plock <= fl[1];
    pidsel <= (k == KIND_CFG) && !fl[2];
    preq <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(negedge clk);
      if (ans()) break;
    end
    if (i == 20) wait_out();
    @(posedge clk);
    preq <= 1'b0;
  endtask

  task automatic pr(input dbra_pci_kind_e k, input logic [31:0] a, input logic [2:0] c,
      input logic [31:0] ed);
    pci(k, a, 1'b0, 32'h0, 4'h0, 3'h0, c, ed);
  endtask

  task automatic pw(input dbra_pci_kind_e k, input logic [31:0] a, input logic [31:0] d);
    pci(k, a, 1'b1, d, 4'h0, 3'h0, DN, 32'h0);
  endtask

  // one VMEbus D32 cycle; hold keeps the address strobe low afterwards
  task automatic vme(input logic [5:0] m, input logic [31:0] a, input logic w,
      input logic [31:0] d, input logic ack, input logic hold, input logic [31:0] ed);
    int i;
    if (ack) vq.push_back({w, ed});
    @(posedge clk);
    am <= m;
    vaddr <= a;
    wr_n <= ~w;
    vdin <= w ? d : ~vdin;
    as_n <= 1'b0;
    @(posedge clk);
    ds_n <= 1'b0;
    for (i = 0; i < 12 && dtack_n !== 1'b0; i++) @(negedge clk);
    if (!ack) chk("dtack absent", 32'h1, {31'h0, dtack_n});
    else if (i == 12) wait_out();
    @(posedge clk);
    ds_n <= 1'b1;
    for (i = 0; i < 12 && dtack_n !== 1'b1; i++) @(negedge clk);
    if (i == 12) wait_out();
    @(posedge clk);
    if (!hold) as_n <= 1'b1;
    vdin <= ~vdin;
    if (!hold) repeat (3) @(posedge clk); // synced strobe must clear before PCI tries
  endtask

  // take the oldest note of a kind whenever that kind of answer shows
  always @(negedge clk) begin
    dt_q <= dtack_n;
    fr_q <= freq;
    if (ans()) begin
      if (pq.size() == 0) chk("pci unexpected", 32'h0, 32'h1);
      else cmp_pci(pq.pop_front());
    end
    if (dtack_n === 1'b0 && dt_q === 1'b1) begin
      if (vq.size() == 0) chk("vme unexpected", 32'h0, 32'h1);
      else cmp_vme(vq.pop_front());
    end
    if (freq === 1'b1 && fr_q !== 1'b1) begin
      if (fq.size() == 0) chk("fwd unexpected", 32'h0, 32'h1);
      else cmp_fwd(fq.pop_front());
    end
  end

  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    chk("reset outputs", 32'h3, {25'h0, pdone, pretry, pnosel, pdisc, freq, dtack_n, voe_n});
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    pr(KIND_CFG, OW0, DN, 32'h1);
    pr(KIND_CFG, OW1, DN, 32'h0);
    pr(KIND_CFG, 32'h0000_0110, DN, 32'h1);
    pw(KIND_CFG, OW1, 32'hFFFF_FFFF);
    pr(KIND_CFG, OW1, DN, 32'hFFFF_F000);
    pw(KIND_CFG, OW0, 32'hFFFF_FFFF);
    pr(KIND_CFG, OW0, DN, 32'hFFFF_F001);
    pw(KIND_CFG, OW1, MB);
    pw(KIND_CFG, OW0, IB);
    pr(KIND_MEM, MB + OIB, DN, 32'hABCD_E000);
    pr(KIND_IO, IB + OIB, DN, 32'hABCD_E000);
    pr(KIND_MEM, IB + OIB, NS, 32'h0);
    pci(KIND_CFG, OW0, 1'b0, 32'h0, 4'h0, 3'h4, NS, 32'h0);
    r = $random(seed) & 32'hFFFF_F000;
    pw(KIND_MEM, MB + OIB, r);
    pci(KIND_MEM, MB + OIB, 1'b1, 32'h1122_3344, 4'h7, 3'h0, DN, 32'h0);
    pr(KIND_MEM, MB + OIB, DN, {8'h11, r[23:0]});
    pw(KIND_MEM, MB + 32'h200, 32'hA5A5_A5A5);
    pci(KIND_MEM, MB + 32'h200, 1'b1, 32'h1122_3344, 4'hE, 3'h0, DN, 32'h0);
    pr(KIND_MEM, MB + 32'h200, DN, 32'hA5A5_A544);
    pci(KIND_MEM, MB + OIB, 1'b1, VB, 4'h0, 3'h1, DN, 32'h0);
    pr(KIND_MEM, MB + OIB, DN, VB);
    for (int v = 0; v < 3; v++) begin
      pw(KIND_MEM, MB + OIC, 32'h8060_0000 | (v << 16));
      vme(amt[v], VB + OIB, 1'b0, 32'h0, 1'b1, 1'b0, VB);
    end
    vme(6'h09, VB + OIB, 1'b0, 32'h0, 1'b0, 1'b0, 32'h0);
    vme(6'h0E, VB + OIB, 1'b0, 32'h0, 1'b0, 1'b0, 32'h0);
    pw(KIND_MEM, MB + OIC, 32'h0062_0000);
    vme(6'h0D, VB + OIB, 1'b0, 32'h0, 1'b0, 1'b0, 32'h0);
    pw(KIND_MEM, MB + OIC, 32'h8062_0000);
    vme(6'h0D, VB + OW0, 1'b1, 32'h0000_7000, 1'b1, 1'b0, 32'h0);
    pr(KIND_CFG, OW0, DN, 32'h0000_7001);
    pr(KIND_IO, 32'h0000_7000 + OIB, DN, VB);
    vme(6'h0D, VB + OCT, 1'b0, 32'h0, 1'b1, 1'b1, 32'h0);
    pr(KIND_MEM, MB + OCT, RT, 32'h0);
    vme(6'h0D, VB + OCT, 1'b1, TO, 1'b1, 1'b0, 32'h0);
    repeat (4) @(posedge clk);
    pr(KIND_MEM, MB + OCT, DN, TO);
    // address-only tenure, as a master locking out the PCI side would use
    bbsy_n <= 1'b0;
    am <= 6'h0D;
    vaddr <= VB + OIC;
    as_n <= 1'b0;
    repeat (6) @(posedge clk);
    as_n <= 1'b1;
    repeat (6) @(posedge clk);
    pr(KIND_MEM, MB + OIC, RT, 32'h0);
    @(posedge clk);
    bbsy_n <= 1'b1;
    repeat (5) @(posedge clk);
    pr(KIND_MEM, MB + OIC, DN, 32'h8062_0000);
    pci(KIND_MEM, MB + OIC, 1'b0, 32'h0, 4'h0, 3'h2, DN, 32'h8062_0000);
    vme(6'h0D, VB + OIC, 1'b0, 32'h0, 1'b0, 1'b0, 32'h0);
    pr(KIND_MEM, MB + OIC, DN, 32'h8062_0000);
    vme(6'h0D, VB + OIC, 1'b0, 32'h0, 1'b1, 1'b0, 32'h8062_0000);
    pw(KIND_MEM, MB + OCB, 32'h0018_0000);
    vme(6'h2F, CS + OIB, 1'b0, 32'h0, 1'b0, 1'b0, 32'h0);
    pw(KIND_MEM, MB + OCC, 32'h8000_0002);
    vme(6'h2F, CS + OIB, 1'b0, 32'h0, 1'b1, 1'b0, VB);
    vme(6'h2F, CS + 32'h0008_0000 + OIB, 1'b0, 32'h0, 1'b0, 1'b0, 32'h0);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      fdly <= 4'(k * 5);
      fq.push_back({1'(k), TO, 2'h2, TO + 32'h0018_0100});
      vme(6'h2F, 32'h0018_0100, 1'(k), TO, 1'b1, 1'b0, FV);
    end
    repeat (4) @(posedge clk);
    chk("notes left", 32'h0, pq.size() + vq.size() + fq.size());
    test_done();
  end
endmodule
`default_nettype wire
